//--- rtl/bss_brake_stop_seq.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - release output only when function assigned
// - power stays on for off delay
// - motion masked for release delay after enable
// - engage speed settable 30 to 3000 RPM
// - decel timeout expiry drops release output
// - speed below threshold drops release early
// - release output follows enable within 500 ms
// - alarm or prohibition while enabled stops only with emergency stop setting
// - emergency stop setting forces stop, alarm
// - limits block their direction or ignored
// - setting two lets limits raise alarm
// - ignore setting applies in homing too
// - braking torque limited to set percent
module bss_brake_stop_seq
  import bss_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // pins from the machine
  input  wire logic         servo_enable_cmd,
  input  wire logic         positive_limit_input,
  input  wire logic         negative_limit_input,
  // drive internal status
  input  wire logic         output_function_select,
  input  wire logic [15:0]  decel_timeout_setting,
  input  wire logic signed [15:0] motor_speed,
  input  wire logic         alarm_in,
  input  wire logic         quick_stop_req,
  input  wire logic         homing_mode,
  // parameter access
  input  wire bss_par_req_t par_req,
  output logic      [15:0]  par_rdata,
  // brake and power
  output logic              brake_release_out,
  output logic              motor_power_on,
  output logic              motion_enable,
  // motion limiting
  output logic              pos_motion_block,
  output logic              neg_motion_block,
  output logic              torque_limit_active,
  output logic      [15:0]  torque_limit_pct,
  // alarms
  output logic              estop_alarm,
  output logic              travel_limit_alarm
);

  bss_core_t   core_reg;
  bss_core_t   core_next;
  logic [2:0]  pins_s;
  logic        en_s;
  logic        pos_s;
  logic        neg_s;
  logic [15:0] spd_abs;
  logic        slow;
  logic        lim_on;
  logic        prohib;
  logic        estop_cause;
  logic        stop_req;
  logic        active;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    else
      return v;
  endfunction

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    logic [15:0] m;
    m = 16'(-v);
    return v[15] ? m : 16'(v);
  endfunction

  // pin inputs cross in from outside the clock domain
  bss_sync3 #(
    .W (3)
  ) u_sync (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pin_in    ({servo_enable_cmd, positive_limit_input, negative_limit_input}),
    .level_out (pins_s)
  );

  assign en_s  = pins_s[2];
  assign pos_s = pins_s[1];
  assign neg_s = pins_s[0];

  // stop causes and speed compare
  always_comb
  begin
    spd_abs     = abs16(motor_speed);
    slow        = spd_abs < core_reg.par.engage_speed;
    lim_on      = core_reg.par.travel_cfg != TRAVEL_IGNORE;
    // homing runs onto the limits, so they are no stop cause there
    prohib      = lim_on && !homing_mode && (pos_s || neg_s);
    active      = core_reg.state != ST_OFF;
    estop_cause = (core_reg.par.estop_en == ESTOP_MAX) && (alarm_in || prohib);
    stop_req    = !en_s || estop_cause || quick_stop_req;
  end

  // single next-state process for the whole sequencer
  always_comb
  begin
    core_next      = core_reg;
    core_next.tick = 1'b0;
    // millisecond enable pulse
    if (core_reg.div == MS_DIV_W'(MS_CYCLES - 1))
    begin
      core_next.div  = '0;
      core_next.tick = 1'b1;
    end
    else
      core_next.div = core_reg.div + MS_DIV_W'(1);

    // parameter writes, clamped to their legal ranges
    if (par_req.wr)
    begin
      unique case (par_req.idx)
        IDX_PWR_OFF_DELAY: core_next.par.pwr_off_delay = clamp16(par_req.wdata, ZERO16,
                                                                 DELAY_MAX_MS);
        IDX_REL_DELAY:     core_next.par.rel_delay = clamp16(par_req.wdata, ZERO16, DELAY_MAX_MS);
        IDX_ENGAGE_SPEED:  core_next.par.engage_speed  = clamp16(par_req.wdata, SPEED_MIN_RPM,
                                                                 SPEED_MAX_RPM);
        IDX_ESTOP_EN:      core_next.par.estop_en      = clamp16(par_req.wdata, ZERO16, ESTOP_MAX);
        IDX_TRAVEL_CFG:    core_next.par.travel_cfg = clamp16(par_req.wdata, ZERO16, TRAVEL_MAX);
        IDX_BRK_TORQUE:    core_next.par.brk_torque    = clamp16(par_req.wdata, ZERO16,
                                                                 TORQUE_MAX_PCT);
        default:           ;
      endcase
    end

    // registered read mux; unknown indices read zero
    unique case (par_req.idx)
      IDX_PWR_OFF_DELAY: core_next.rdata = core_reg.par.pwr_off_delay;
      IDX_REL_DELAY:     core_next.rdata = core_reg.par.rel_delay;
      IDX_ENGAGE_SPEED:  core_next.rdata = core_reg.par.engage_speed;
      IDX_ESTOP_EN:      core_next.rdata = core_reg.par.estop_en;
      IDX_TRAVEL_CFG:    core_next.rdata = core_reg.par.travel_cfg;
      IDX_BRK_TORQUE:    core_next.rdata = core_reg.par.brk_torque;
      IDX_STATUS:        core_next.rdata = {8'h00, core_reg.tl_alarm, core_reg.est_alarm,
                                            core_reg.mot_en, core_reg.pwr, core_reg.brk,
                                            core_reg.state};
      default:           core_next.rdata = ZERO16;
    endcase

    // brake and power sequence
    unique case (core_reg.state)
      ST_OFF:
      begin
        core_next.mot_en  = 1'b0;
        core_next.trq_act = 1'b0;
        if (en_s && !stop_req)
        begin
          core_next.state = ST_RELEASE;
          core_next.pwr   = 1'b1;
          core_next.cnt   = '0;
        end
      end
      ST_RELEASE:
      begin
        // position held and commands masked while the brake lifts
        if (stop_req)
        begin
          core_next.state   = ST_DECEL;
          core_next.trq_act = 1'b1;
          core_next.cnt     = '0;
        end
        else if (core_reg.cnt >= core_reg.par.rel_delay)
        begin
          core_next.state  = ST_RUN;
          core_next.mot_en = 1'b1;
        end
        else if (core_reg.tick)
          core_next.cnt = core_reg.cnt + 16'h0001;
      end
      ST_RUN:
      begin
        if (stop_req)
        begin
          core_next.state   = ST_DECEL;
          core_next.mot_en  = 1'b0;
          core_next.trq_act = 1'b1;
          core_next.cnt     = '0;
        end
      end
      ST_DECEL:
      begin
        // whichever of timeout and low speed comes first engages the brake
        if (slow || core_reg.cnt >= decel_timeout_setting)
        begin
          core_next.state   = ST_PWROFF;
          core_next.trq_act = 1'b0;
          core_next.cnt     = '0;
        end
        else if (core_reg.tick)
          core_next.cnt = core_reg.cnt + 16'h0001;
      end
      ST_PWROFF:
      begin
        // power held so the axis cannot slide before the brake bites
        if (core_reg.cnt >= core_reg.par.pwr_off_delay)
        begin
          core_next.state = ST_OFF;
          core_next.pwr   = 1'b0;
        end
        else if (core_reg.tick)
          core_next.cnt = core_reg.cnt + 16'h0001;
      end
      default:
      begin
        core_next.state = ST_OFF;
        core_next.pwr   = 1'b0;
      end
    endcase

    // release output only when mapped and the brake should be lifted
    core_next.brk = output_function_select && (core_next.state == ST_RELEASE ||
                    core_next.state == ST_RUN || core_next.state == ST_DECEL);

    // direction blocking
    core_next.pos_blk = lim_on && pos_s;
    core_next.neg_blk = lim_on && neg_s;

    // sticky alarms: cleared once disabled and idle, but a new cause wins
    if (!en_s && core_reg.state == ST_OFF)
    begin
      core_next.est_alarm = 1'b0;
      core_next.tl_alarm  = 1'b0;
    end
    if (active && estop_cause)
      core_next.est_alarm = 1'b1;
    if (active && core_reg.par.travel_cfg == TRAVEL_ALARM && (pos_s || neg_s))
      core_next.tl_alarm = 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_reg       <= '0;
      core_reg.state <= ST_OFF;
      core_reg.par   <= PARAMS_RST;
    end
    else
      core_reg <= core_next;
  end

  assign par_rdata           = core_reg.rdata;
  assign brake_release_out   = core_reg.brk;
  assign motor_power_on      = core_reg.pwr;
  assign motion_enable       = core_reg.mot_en;
  assign pos_motion_block    = core_reg.pos_blk;
  assign neg_motion_block    = core_reg.neg_blk;
  assign torque_limit_active = core_reg.trq_act;
  assign torque_limit_pct    = core_reg.par.brk_torque;
  assign estop_alarm         = core_reg.est_alarm;
  assign travel_limit_alarm  = core_reg.tl_alarm;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_rel_needs_sel;
    brake_release_out |-> $past(output_function_select);
  endproperty
  a_rel_needs_sel: assert property (p_rel_needs_sel) else $error("release while unmapped");

  property p_pwr_off_delay;
    $fell(motor_power_on) |-> $past(core_reg.cnt) >= $past(core_reg.par.pwr_off_delay);
  endproperty
  a_pwr_off_delay: assert property (p_pwr_off_delay) else $error("power removed early");

  property p_rel_delay;
    $rose(motion_enable) |-> $past(core_reg.cnt) >= $past(core_reg.par.rel_delay);
  endproperty
  a_rel_delay: assert property (p_rel_delay) else $error("motion unmasked early");

  property p_speed_range;
    core_reg.par.engage_speed >= SPEED_MIN_RPM && core_reg.par.engage_speed <= SPEED_MAX_RPM;
  endproperty
  a_speed_range: assert property (p_speed_range) else $error("engage speed out of range");

  property p_timeout_drop;
    core_reg.state == ST_DECEL && core_reg.cnt >= decel_timeout_setting
      |=> !brake_release_out && core_reg.state == ST_PWROFF;
  endproperty
  a_timeout_drop: assert property (p_timeout_drop) else $error("no drop at timeout");

  property p_slow_drop;
    core_reg.state == ST_DECEL && slow |=> !brake_release_out;
  endproperty
  a_slow_drop: assert property (p_slow_drop) else $error("no drop at low speed");

  property p_enable_fast;
    core_reg.state == ST_OFF && en_s && !stop_req && output_function_select
      |=> brake_release_out;
  endproperty
  a_enable_fast: assert property (p_enable_fast) else $error("release not given");

  property p_estop;
    core_reg.state == ST_RUN && core_reg.par.estop_en == ESTOP_MAX && alarm_in
      |=> core_reg.state == ST_DECEL && estop_alarm && !motion_enable;
  endproperty
  a_estop: assert property (p_estop) else $error("emergency stop missed");

  property p_block;
    core_reg.par.travel_cfg == TRAVEL_BLOCK && pos_s |=> pos_motion_block;
  endproperty
  a_block: assert property (p_block) else $error("positive limit not blocking");

  property p_tl_alarm;
    active && core_reg.par.travel_cfg == TRAVEL_ALARM && neg_s |=> travel_limit_alarm;
  endproperty
  a_tl_alarm: assert property (p_tl_alarm) else $error("travel alarm missed");

  property p_torque;
    torque_limit_active |-> torque_limit_pct <= TORQUE_MAX_PCT && core_reg.state == ST_DECEL;
  endproperty
  a_torque: assert property (p_torque) else $error("torque limit outside braking");

  c_run:     cover property (core_reg.state == ST_RELEASE ##1 core_reg.state == ST_RUN);
  c_slow:    cover property (core_reg.state == ST_DECEL && slow);
  c_timeout: cover property (core_reg.state == ST_DECEL && !slow && core_reg.cnt != 16'h0000);
  c_estop:   cover property ($rose(estop_alarm));

endmodule // bss_brake_stop_seq
`default_nettype wire

//--- rtl/bss_pkg.sv
package bss_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES_DEF   = MS_NS / CLK_PERIOD_NS;
  localparam int MS_DIV_W        = 17;
  localparam int RELEASE_MAX_MS  = 500;

  // parameter indices as printed
  localparam logic [15:0] IDX_PWR_OFF_DELAY = 16'h2437;
  localparam logic [15:0] IDX_REL_DELAY     = 16'h2438;
  localparam logic [15:0] IDX_ENGAGE_SPEED  = 16'h2439;
  localparam logic [15:0] IDX_ESTOP_EN      = 16'h2443;
  localparam logic [15:0] IDX_TRAVEL_CFG    = 16'h2504;
  localparam logic [15:0] IDX_BRK_TORQUE    = 16'h2511;
  localparam logic [15:0] IDX_STATUS        = 16'h2FF0;

  // reset values
  localparam logic [15:0] RST_PWR_OFF_DELAY = 16'h0064;
  localparam logic [15:0] RST_REL_DELAY     = 16'h0000;
  localparam logic [15:0] RST_ENGAGE_SPEED  = 16'h001E;
  localparam logic [15:0] RST_ESTOP_EN      = 16'h0000;
  localparam logic [15:0] RST_TRAVEL_CFG    = 16'h0000;
  localparam logic [15:0] RST_BRK_TORQUE    = 16'h0000;

  // legal ranges; writes are clamped into them
  localparam logic [15:0] DELAY_MAX_MS      = 16'h0BB8;
  localparam logic [15:0] SPEED_MIN_RPM     = 16'h001E;
  localparam logic [15:0] SPEED_MAX_RPM     = 16'h0BB8;
  localparam logic [15:0] ESTOP_MAX         = 16'h0001;
  localparam logic [15:0] TRAVEL_MAX        = 16'h0002;
  localparam logic [15:0] TORQUE_MAX_PCT    = 16'h01F4;
  localparam logic [15:0] ZERO16            = 16'h0000;

  // travel inhibit codes
  localparam logic [15:0] TRAVEL_BLOCK      = 16'h0000;
  localparam logic [15:0] TRAVEL_IGNORE     = 16'h0001;
  localparam logic [15:0] TRAVEL_ALARM      = 16'h0002;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RELEASE,
    ST_RUN,
    ST_DECEL,
    ST_PWROFF
  } bss_state_t;

  typedef struct packed {
    logic [15:0] pwr_off_delay;
    logic [15:0] rel_delay;
    logic [15:0] engage_speed;
    logic [15:0] estop_en;
    logic [15:0] travel_cfg;
    logic [15:0] brk_torque;
  } bss_params_t;

  localparam bss_params_t PARAMS_RST = '{
    pwr_off_delay: RST_PWR_OFF_DELAY,
    rel_delay:     RST_REL_DELAY,
    engage_speed:  RST_ENGAGE_SPEED,
    estop_en:      RST_ESTOP_EN,
    travel_cfg:    RST_TRAVEL_CFG,
    brk_torque:    RST_BRK_TORQUE
  };

  // parameter port carrier
  typedef struct packed {
    logic        wr;
    logic [15:0] idx;
    logic [15:0] wdata;
  } bss_par_req_t;

  typedef struct packed {
    bss_state_t          state;
    logic [MS_DIV_W-1:0] div;
    logic                tick;
    logic [15:0]         cnt;
    bss_params_t         par;
    logic                brk;
    logic                pwr;
    logic                mot_en;
    logic                pos_blk;
    logic                neg_blk;
    logic                trq_act;
    logic                est_alarm;
    logic                tl_alarm;
    logic [15:0]         rdata;
  } bss_core_t;

endpackage

//--- rtl/bss_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module bss_sync3
  import bss_pkg::*;
#(
  parameter int W = 3
)(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } bss_sync_t;

  bss_sync_t sync_reg;
  bss_sync_t sync_next;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_comb
  begin
    sync_next    = sync_reg;
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < W; i++)
    begin
      if (sync_reg.s2[i] == sync_reg.s3[i])
        sync_next.lvl[i] = sync_reg.s3[i];
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign level_out = sync_reg.lvl;

endmodule // bss_sync3
`default_nettype wire

//--- dv/bss_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module bss_drive_model
  import bss_pkg::*;
(
  // clock
  input  wire logic               mclk,
  // commands from the bench
  input  wire logic               en_req,
  input  wire logic               qs_req,
  input  wire logic signed [15:0] run_speed,
  input  wire logic        [15:0] decel_step,
  // drive side
  input  wire logic               motion_enable,
  output logic                    servo_enable_cmd,
  output logic                    quick_stop_req,
  output logic signed [15:0]      motor_speed
);
  // the enable pin and the master quick stop follow the bench at once
  assign servo_enable_cmd = en_req;
  assign quick_stop_req   = qs_req;

  // speed jumps to the command while motion runs, else coasts toward zero;
  // a step of zero models a load that never slows, so only the timeout helps
  always @(posedge mclk)
  begin
    if (motion_enable)
      motor_speed <= run_speed;
    else if (motor_speed > $signed({1'b0, decel_step[14:0]}))
      motor_speed <= motor_speed - $signed({1'b0, decel_step[14:0]});
    else if (motor_speed < -$signed({1'b0, decel_step[14:0]}))
      motor_speed <= motor_speed + $signed({1'b0, decel_step[14:0]});
    else
      motor_speed <= 16'sh0000;
  end
endmodule // bss_drive_model
`default_nettype wire

//--- dv/bss_brake_stop_seq_test.sv
`timescale 1ns/1ns
`default_nettype none
module bss_brake_stop_seq_test
  import bss_pkg::*;
;
  localparam int MSC = 10;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic en_req = 1'b0, qs_req = 1'b0, func = 1'b1, pos_lim = 1'b0, neg_lim = 1'b0;
  logic alarm = 1'b0, homing = 1'b0;
  logic signed [15:0] run_speed = 16'sh0000;
  logic [15:0] step = 16'h0064, tmo = 16'h0032, rd, tpct;
  bss_par_req_t req = '0;
  logic servo_en, qs, brk, pwr, men, pblk, nblk, trq, ealm, talm;
  logic signed [15:0] speed;
  int fails = 0, compares = 0, cyc = 0;

  always #5 mclk = ~mclk;

  bss_drive_model model_u (.mclk(mclk), .en_req(en_req), .qs_req(qs_req),
    .run_speed(run_speed), .decel_step(step), .motion_enable(men),
    .servo_enable_cmd(servo_en), .quick_stop_req(qs), .motor_speed(speed));

  bss_brake_stop_seq #(.MS_CYCLES(MSC)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .servo_enable_cmd(servo_en), .positive_limit_input(pos_lim),
    .negative_limit_input(neg_lim), .output_function_select(func),
    .decel_timeout_setting(tmo), .motor_speed(speed), .alarm_in(alarm),
    .quick_stop_req(qs), .homing_mode(homing), .par_req(req), .par_rdata(rd),
    .brake_release_out(brk), .motor_power_on(pwr), .motion_enable(men),
    .pos_motion_block(pblk), .neg_motion_block(nblk), .torque_limit_active(trq),
    .torque_limit_pct(tpct), .estop_alarm(ealm), .travel_limit_alarm(talm));

  // a hung wait must still reach the verdict
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int n);
    compares++;
    if (n < lo || n > hi)
    begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return brk;
      1: return pwr;
      2: return men;
      default: return trq;
    endcase
  endfunction

  // sampled at the falling edge, where outputs have settled
  task automatic wait_lvl(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(w) !== lvl && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic par_wr(input logic [15:0] idx, input logic [15:0] data);
    @(negedge mclk);
    req = '{wr: 1'b1, idx: idx, wdata: data};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  // index applied, read data registered one edge later
  task automatic par_rd(input logic [15:0] idx, output logic [15:0] data);
    @(negedge mclk);
    req.idx = idx;
    repeat (2) @(negedge mclk);
    data = rd;
  endtask

  task automatic go_on(output int n);
    en_req = 1'b1;
    wait_lvl(0, 1'b1, 20, n);
    if (func === 1'b0)
      wait_lvl(1, 1'b1, 20, n);
  endtask

  task automatic go_off();
    int n;
    en_req = 1'b0;
    wait_lvl(1, 1'b0, 300, n);
    repeat (6) @(negedge mclk);
  endtask

  task automatic t_regs();
    logic [15:0] ix [6] = '{IDX_PWR_OFF_DELAY, IDX_REL_DELAY, IDX_ENGAGE_SPEED,
                            IDX_ESTOP_EN, IDX_TRAVEL_CFG, IDX_BRK_TORQUE};
    logic [15:0] rv [6] = '{16'h0064, 16'h0000, 16'h001E, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] wv [6] = '{16'h1000, 16'h0BB8, 16'h0005, 16'h0003, 16'h0005, 16'h0300};
    logic [15:0] cv [6] = '{16'h0BB8, 16'h0BB8, 16'h001E, 16'h0001, 16'h0002, 16'h01F4};
    logic [15:0] v;
    for (int i = 0; i < 6; i++)
    begin
      par_rd(ix[i], v);
      chk("reset value", rv[i], v);
      par_wr(ix[i], wv[i]);
      par_rd(ix[i], v);
      chk("clamped value", cv[i], v);
    end
    par_wr(IDX_ENGAGE_SPEED, 16'h0BB9);
    par_rd(IDX_ENGAGE_SPEED, v);
    chk("speed upper bound", 16'h0BB8, v);
    par_wr(16'h1234, 16'h0055);
    par_rd(16'h1234, v);
    chk("unmapped read", 16'h0000, v);
    // working set for the sequences below
    par_wr(IDX_PWR_OFF_DELAY, 16'h0004);
    par_wr(IDX_REL_DELAY, 16'h0003);
    par_wr(IDX_ENGAGE_SPEED, 16'h001E);
    par_wr(IDX_ESTOP_EN, 16'h0000);
    par_wr(IDX_TRAVEL_CFG, 16'h0000);
    par_wr(IDX_BRK_TORQUE, 16'h0096);
    $display("test regs done");
  endtask

  // enable, release delay, then a reverse spin that coasts below threshold
  task automatic t_release_and_ramp();
    int n;
    logic [15:0] v;
    go_on(n);
    chk_rng("enable to release cycles", 1, 10, n);
    chk("power on", 16'h0001, {15'h0, pwr});
    chk("motion masked", 16'h0000, {15'h0, men});
    wait_lvl(2, 1'b1, 60, n);
    chk_rng("release delay cycles", 20, 32, n);
    par_rd(IDX_STATUS, v);
    chk("status in run", 16'h003A, v);
    run_speed = -16'sd1000;
    repeat (3) @(negedge mclk);
    en_req = 1'b0;
    wait_lvl(3, 1'b1, 10, n);
    chk_rng("disable to braking cycles", 1, 8, n);
    chk("braking torque", 16'h0096, tpct);
    chk("motion off in braking", 16'h0000, {15'h0, men});
    wait_lvl(0, 1'b0, 40, n);
    chk_rng("slow speed brake drop cycles", 8, 14, n);
    wait_lvl(1, 1'b0, 60, n);
    chk_rng("power off delay cycles", 30, 42, n);
    go_off();
    $display("test release and ramp done");
  endtask

  task automatic t_decel_timeout();
    int n;
    step = 16'h0000;
    run_speed = 16'sd1000;
    tmo = 16'h0005;
    go_on(n);
    wait_lvl(2, 1'b1, 60, n);
    en_req = 1'b0;
    wait_lvl(3, 1'b1, 10, n);
    wait_lvl(0, 1'b0, 80, n);
    chk_rng("timeout brake drop cycles", 40, 52, n);
    go_off();
    step = 16'h0064;
    run_speed = 16'sh0000;
    tmo = 16'h0032;
    $display("test decel timeout done");
  endtask

  // limits with the release function unassigned, each inhibit code in turn
  task automatic t_limits();
    int n;
    logic [2:0] blk = 3'b101;
    logic [2:0] alm = 3'b100;
    func = 1'b0;
    go_on(n);
    repeat (8) @(negedge mclk);
    chk("release unassigned", 16'h0000, {15'h0, brk});
    for (int c = 0; c < 3; c++)
    begin
      par_wr(IDX_TRAVEL_CFG, 16'(c));
      homing = (c == 1);
      pos_lim = 1'b1;
      repeat (8) @(negedge mclk);
      chk("positive block", {15'h0, blk[c]}, {15'h0, pblk});
      chk("negative free", 16'h0000, {15'h0, nblk});
      chk("travel alarm", {15'h0, alm[c]}, {15'h0, talm});
      pos_lim = 1'b0;
      neg_lim = 1'b1;
      repeat (8) @(negedge mclk);
      chk("negative block", {15'h0, blk[c]}, {15'h0, nblk});
      chk("positive free", 16'h0000, {15'h0, pblk});
      neg_lim = 1'b0;
    end
    homing = 1'b0;
    go_off();
    chk("travel alarm cleared", 16'h0000, {15'h0, talm});
    par_wr(IDX_TRAVEL_CFG, 16'h0000);
    func = 1'b1;
    $display("test limits done");
  endtask

  task automatic t_estop();
    int n;
    go_on(n);
    alarm = 1'b1;
    repeat (10) @(negedge mclk);
    chk("no forced stop", 16'h0001, {15'h0, pwr & ~trq});
    chk("no estop alarm", 16'h0000, {15'h0, ealm});
    alarm = 1'b0;
    par_wr(IDX_ESTOP_EN, 16'h0001);
    wait_lvl(2, 1'b1, 60, n);
    alarm = 1'b1;
    wait_lvl(3, 1'b1, 10, n);
    chk_rng("alarm stop cycles", 1, 8, n);
    chk("motion off at stop", 16'h0000, {15'h0, men});
    chk("estop alarm", 16'h0001, {15'h0, ealm});
    alarm = 1'b0;
    go_off();
    go_on(n);
    pos_lim = 1'b1;
    wait_lvl(3, 1'b1, 10, n);
    chk_rng("prohibition stop cycles", 4, 6, n);
    chk("prohibition alarm", 16'h0001, {15'h0, ealm});
    pos_lim = 1'b0;
    go_off();
    par_wr(IDX_ESTOP_EN, 16'h0000);
    go_on(n);
    qs_req = 1'b1;
    wait_lvl(3, 1'b1, 10, n);
    chk_rng("quick stop cycles", 1, 8, n);
    qs_req = 1'b0;
    go_off();
    $display("test estop done");
  endtask

  initial
  begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    t_regs();
    t_release_and_ramp();
    t_decel_timeout();
    t_limits();
    t_estop();
    tally_and_finish();
  end
endmodule // bss_brake_stop_seq_test
`default_nettype wire
